//--- design/phy_management_access.v
// phy management access: command registers and serial management engine
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "phy_mgmt_consts.vh"
module phy_management_access #(
    parameter INT_PHY_PORT = 5'h0_0,
    parameter MDC_HALF     = `MDC_HALF_CYCLES
) (
    input  wire        ref_clk_i,
    input  wire        nrst_i,
    input  wire [11:0] addr_i,
    input  wire [31:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [31:0] rdata_o,
    output wire        irq_o,
    input  wire        nv_load_i,
    input  wire [4:0]  nv_phy_port_i,
    input  wire        nv_dest_i,
    input  wire        mgmt_pins_en_i,
    output reg         ext_mdc_o,
    input  wire        ext_mdio_i,
    output reg         ext_mdio_o,
    output reg         ext_mdio_oe_o,
    output reg         int_mdc_o,
    input  wire        int_mdio_i,
    output reg         int_mdio_o,
    output reg         int_mdio_oe_o
);
    // -------------------------------------------------------------------------
    // states
    // -------------------------------------------------------------------------
    localparam ST_IDLE  = 2'b01;
    localparam ST_SHIFT = 2'b10;

    reg  [1:0]  state;
    reg  [15:0] cmd_data;
    reg  [4:0]  phy_reg_index;
    reg  [1:0]  transfer_opcode;
    reg         ready_flag;
    reg         completion_irq_enable;
    reg         read_fail_flag;
    reg  [4:0]  external_phy_port;
    reg         dest_external;
    reg  [1:0]  irq_status;
    reg  [1:0]  irq_enable;
    reg         irq_done_gate;

    reg  [63:0] frame;
    reg  [5:0]  bit_cnt;
    reg         mdc;
    reg         drive;
    reg         is_read;
    reg         to_external;
    reg         fail_seen;
    reg  [15:0] shift_in;

    wire        tick;
    wire        ext_mdio_s;
    wire        int_mdio_s;
    wire        mdio_s;
    wire        running;
    wire        wr_cmd;
    wire        op_valid;
    wire        start;
    wire        finish;
    wire [4:0]  port_sel;

    assign running  = (state == ST_SHIFT);
    assign wr_cmd   = wr_i && (addr_i == `CMD_OFFSET);
    assign op_valid = (wdata_i[`CMD_OP_MSB:`CMD_OP_LSB] == `OP_WRITE) ||
                      (wdata_i[`CMD_OP_MSB:`CMD_OP_LSB] == `OP_READ);
    // a command needs ready written low, a legal code, idle engine and live pins
    assign start    = wr_cmd && op_valid && !wdata_i[`CMD_READY_BIT] &&
                      (state == ST_IDLE) && mgmt_pins_en_i;
    assign finish   = running && tick && mdc && (bit_cnt == 6'd63);
    // internal phy uses a fixed port, external one the configured port
    assign port_sel = wdata_dest_port(dest_external, external_phy_port);
    assign mdio_s   = to_external ? ext_mdio_s : int_mdio_s;

    function [4:0] wdata_dest_port;
        input       ext;
        input [4:0] port;
        begin
            wdata_dest_port = ext ? port : INT_PHY_PORT[4:0];
        end
    endfunction

    // -------------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------------
    mdc_divider #(
        .HALF_CYCLES (MDC_HALF),
        .CNT_W       (8)
    ) u_div (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .run_i     (running),
        .tick_o    (tick)
    );

    pin_sync u_ext_sync (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .pin_i     (ext_mdio_i),
        .level_o   (ext_mdio_s)
    );

    pin_sync u_int_sync (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .pin_i     (int_mdio_i),
        .level_o   (int_mdio_s)
    );

    // -------------------------------------------------------------------------
    // command and configuration registers
    // -------------------------------------------------------------------------
    always @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            cmd_data              <= 16'h0000;
            phy_reg_index         <= 5'h00;
            transfer_opcode       <= 2'h0;
            ready_flag            <= `READY_RESET;
            completion_irq_enable <= 1'b0;
            read_fail_flag        <= 1'b0;
            external_phy_port     <= 5'h00;
            dest_external         <= 1'b0;
        end
        else
        begin
            // command writes while a transfer runs are dropped so the frame stays intact
            if (wr_cmd && !running)
            begin
                cmd_data              <= wdata_i[`CMD_DATA_MSB:`CMD_DATA_LSB];
                phy_reg_index         <= wdata_i[`CMD_REG_MSB:`CMD_REG_LSB];
                transfer_opcode       <= wdata_i[`CMD_OP_MSB:`CMD_OP_LSB];
                completion_irq_enable <= wdata_i[`CMD_IE_BIT];
                read_fail_flag        <= wdata_i[`CMD_ERR_BIT];
                // an ignored command keeps ready so software is not left waiting
                ready_flag            <= start ? 1'b0 : 1'b1;
            end
            if (finish)
            begin
                ready_flag <= 1'b1;
                if (is_read)
                begin
                    cmd_data <= shift_in;
                    if (fail_seen)
                        read_fail_flag <= 1'b1;
                end
            end
            if (nv_load_i)
            begin
                external_phy_port <= nv_phy_port_i;
                dest_external     <= nv_dest_i;
            end
            else if (wr_i && (addr_i == `CFG_OFFSET))
            begin
                external_phy_port <= wdata_i[`CFG_PORT_MSB:`CFG_PORT_LSB];
                dest_external     <= wdata_i[`CFG_DEST_BIT];
            end
        end
    end

    // -------------------------------------------------------------------------
    // serial engine
    // -------------------------------------------------------------------------
    always @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            state       <= ST_IDLE;
            frame       <= 64'h0000_0000_0000_0000;
            bit_cnt     <= 6'd0;
            mdc         <= 1'b0;
            drive       <= 1'b0;
            is_read     <= 1'b0;
            to_external <= 1'b0;
            fail_seen   <= 1'b0;
            shift_in    <= 16'h0000;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    mdc   <= 1'b0;
                    drive <= 1'b0;
                    if (start)
                    begin
                        state       <= ST_SHIFT;
                        bit_cnt     <= 6'd0;
                        is_read     <= (wdata_i[`CMD_OP_MSB:`CMD_OP_LSB] == `OP_READ);
                        to_external <= dest_external;
                        fail_seen   <= 1'b0;
                        drive       <= 1'b1;
                        // preamble, start, opcode, port, register, turnaround, data
                        frame <= {32'hffff_ffff, `START_CODE,
                                  wdata_i[`CMD_OP_MSB:`CMD_OP_LSB], port_sel,
                                  wdata_i[`CMD_REG_MSB:`CMD_REG_LSB], `TA_WRITE,
                                  wdata_i[`CMD_DATA_MSB:`CMD_DATA_LSB]};
                    end
                end
                ST_SHIFT:
                begin
                    if (tick && !mdc)
                    begin
                        // rising edge: the phy's data are sampled here
                        mdc <= 1'b1;
                        if (is_read && (bit_cnt == `TA_LAST_BIT) && mdio_s)
                            fail_seen <= 1'b1;
                        // every data bit, the last one too, is taken on a rise:
                        // the phy may let go of the line right after it
                        if (is_read && (bit_cnt >= `DATA_FIRST_BIT))
                            shift_in <= {shift_in[14:0], mdio_s};
                    end
                    else if (tick && mdc)
                    begin
                        // falling edge: next bit is set up half a period early
                        mdc <= 1'b0;
                        if (bit_cnt == 6'd63)
                        begin
                            state <= ST_IDLE;
                            drive <= 1'b0;
                        end
                        else
                        begin
                            bit_cnt <= bit_cnt + 1'b1;
                            frame   <= {frame[62:0], 1'b0};
                            // release the line from the turnaround on for a read
                            if (is_read && (bit_cnt == `TA_FIRST_BIT - 1))
                                drive <= 1'b0;
                        end
                    end
                end
                default:
                begin
                    state <= ST_IDLE;
                    drive <= 1'b0;
                    mdc   <= 1'b0;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // pads
    // -------------------------------------------------------------------------
    // disabled pads are held quiet, not driven, so an external phy sees no clock
    always @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            ext_mdc_o     <= 1'b0;
            ext_mdio_o    <= 1'b0;
            ext_mdio_oe_o <= 1'b0;
            int_mdc_o     <= 1'b0;
            int_mdio_o    <= 1'b0;
            int_mdio_oe_o <= 1'b0;
        end
        else
        begin
            ext_mdc_o     <= mgmt_pins_en_i && to_external && mdc;
            ext_mdio_o    <= mgmt_pins_en_i && frame[63];
            ext_mdio_oe_o <= mgmt_pins_en_i && to_external && drive && running;
            int_mdc_o     <= !to_external && mdc;
            int_mdio_o    <= frame[63];
            int_mdio_oe_o <= !to_external && drive && running;
        end
    end

    // -------------------------------------------------------------------------
    // interrupt status, enable and clear
    // -------------------------------------------------------------------------
    always @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            irq_status    <= 2'h0;
            irq_enable    <= 2'h0;
            irq_done_gate <= 1'b0;
        end
        else
        begin
            if (wr_i && (addr_i == `IRQ_ENABLE_OFFSET))
                irq_enable <= wdata_i[1:0];
            // a completion landing with a clear keeps its bit: set wins
            if (wr_i && (addr_i == `IRQ_CLEAR_OFFSET))
                irq_status <= irq_status & ~wdata_i[1:0];
            if (finish)
            begin
                irq_status[`IRQ_DONE_BIT] <= 1'b1;
                irq_done_gate             <= completion_irq_enable;
                if (is_read && fail_seen)
                    irq_status[`IRQ_FAIL_BIT] <= 1'b1;
            end
        end
    end

    assign irq_o = (irq_status[`IRQ_DONE_BIT] && irq_enable[`IRQ_DONE_BIT] && irq_done_gate) ||
                   (irq_status[`IRQ_FAIL_BIT] && irq_enable[`IRQ_FAIL_BIT]);

    // -------------------------------------------------------------------------
    // read port
    // -------------------------------------------------------------------------
    always @(posedge ref_clk_i)
    begin
        if (!nrst_i)
            rdata_o <= 32'h0000_0000;
        else if (rd_i)
        begin
            case (addr_i)
                `CMD_OFFSET:
                    rdata_o <= {1'b0, read_fail_flag, completion_irq_enable, ready_flag,
                                transfer_opcode, 5'h00, phy_reg_index, cmd_data};
                `CFG_OFFSET:
                    rdata_o <= {dest_external, 5'h00, external_phy_port, 21'h00_0000};
                `IRQ_STATUS_OFFSET:
                    rdata_o <= {30'h0000_0000, irq_status};
                `IRQ_ENABLE_OFFSET:
                    rdata_o <= {30'h0000_0000, irq_enable};
                default:
                    rdata_o <= 32'h0000_0000;
            endcase
        end
        else
            rdata_o <= 32'h0000_0000;
    end
endmodule // phy_management_access

//--- design/phy_mgmt_consts.vh
// constants for the phy management access block
`ifndef PHY_MGMT_CONSTS_VH
`define PHY_MGMT_CONSTS_VH

// -----------------------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------------------
`define CMD_OFFSET        12'h020
`define CFG_OFFSET        12'he04
`define IRQ_STATUS_OFFSET 12'h028
`define IRQ_ENABLE_OFFSET 12'h02c
`define IRQ_CLEAR_OFFSET  12'h030

// -----------------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------------
`define CMD_DATA_MSB      15
`define CMD_DATA_LSB      0
`define CMD_REG_MSB       20
`define CMD_REG_LSB       16
`define CMD_OP_MSB        27
`define CMD_OP_LSB        26
`define CMD_READY_BIT     28
`define CMD_IE_BIT        29
`define CMD_ERR_BIT       30
`define CFG_PORT_MSB      25
`define CFG_PORT_LSB      21
`define CFG_DEST_BIT      31
`define IRQ_DONE_BIT      0
`define IRQ_FAIL_BIT      1

// -----------------------------------------------------------------------------
// encodings and reset values
// -----------------------------------------------------------------------------
`define OP_WRITE          2'h1
`define OP_READ           2'h2
`define READY_RESET       1'h1
`define START_CODE        2'h1
`define TA_WRITE          2'h2

// -----------------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------------
`define CLK_PERIOD_NS     8
`define MDC_HALF_NS       200
`define MDC_HALF_CYCLES   ((`MDC_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FRAME_BITS        64
`define TA_LAST_BIT       47
`define DATA_FIRST_BIT    48
`define TA_FIRST_BIT      46

`endif

//--- design/mdc_divider.v
// half-period tick generator for the management clock
`timescale 1ns/1ps
module mdc_divider #(
    parameter HALF_CYCLES = 25,
    parameter CNT_W       = 8
) (
    input  wire ref_clk_i,
    input  wire nrst_i,
    input  wire run_i,
    output reg  tick_o
);
    reg [CNT_W-1:0] count;

    // restarts on every frame so the first half period is full length
    always @(posedge ref_clk_i)
    begin
        if (!nrst_i || !run_i)
        begin
            count  <= {CNT_W{1'b0}};
            tick_o <= 1'b0;
        end
        else if (count == HALF_CYCLES[CNT_W-1:0] - 1'b1)
        begin
            count  <= {CNT_W{1'b0}};
            tick_o <= 1'b1;
        end
        else
        begin
            count  <= count + 1'b1;
            tick_o <= 1'b0;
        end
    end
endmodule // mdc_divider

//--- design/pin_sync.v
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
module pin_sync (
    input  wire ref_clk_i,
    input  wire nrst_i,
    input  wire pin_i,
    output reg  level_o
);
    reg stage1;
    reg stage2;
    reg stage3;

    // a change counts only once the second and third stages agree
    always @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            stage1  <= 1'b1;
            stage2  <= 1'b1;
            stage3  <= 1'b1;
            level_o <= 1'b1;
        end
        else
        begin
            stage1 <= pin_i;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3)
                level_o <= stage3;
        end
    end
endmodule // pin_sync

//--- testbench/phy_model.sv
// behavioural management phy that answers one port address
`timescale 1ns/1ps
module phy_model #(
    parameter logic [4:0] PORT = 5'h00
) (
    input  wire logic mdc_i,
    input  wire logic mdio_i,
    input  wire logic fail_i,
    output logic      drv_o,
    output logic      val_o
);
    logic [15:0] mem [0:31];
    logic [15:0] sh = 16'h0000;
    logic [4:0]  port = 5'h00;
    logic [4:0]  ra = 5'h00;
    logic        rd = 1'b0;
    int          pos = 0;
    int          pre = 0;
    int          npre = 0;

    initial
    begin
        drv_o = 1'b0;
        val_o = 1'b1;
    end

    // ----------------------------------------
    // frame decode: sample on the rise, drive the next bit right after it
    // ----------------------------------------
    always @(posedge mdc_i)
    begin
        sh = {sh[14:0], mdio_i};
        if (pos == 0)
        begin
            if (sh[1:0] == 2'b01 && pre > 0)
            begin
                pos = 33;
                npre = pre;
                pre = 0;
            end
            else if (mdio_i)
                pre = pre + 1;
        end
        else
        begin
            pos = pos + 1;
            if (pos == 35)
                rd = (sh[1:0] == 2'b10);
            if (pos == 40)
                port = sh[4:0];
            if (pos == 45)
                ra = sh[4:0];
            // a silent phy leaves turnaround to the pull-up, seen as a failed read
            if (pos == 46 && rd && port == PORT && !fail_i)
                drv_o = 1'b1;
            val_o = (pos == 46) ? 1'b0 : mem[ra][(62 - pos) & 15];
            if (pos == 63)
            begin
                drv_o = 1'b0;
                if (!rd && port == PORT)
                    mem[ra] = sh;
                pos = 0;
            end
        end
    end
endmodule // phy_model

//--- testbench/phy_mgmt_checker_assertions.sv
// concurrent checks on the phy management access ports
`timescale 1ns/1ps
`include "phy_mgmt_consts.vh"
module phy_mgmt_checker #(
    parameter MDC_HALF = 25
) (
    input logic        ref_clk_i,
    input logic        nrst_i,
    input logic [11:0] addr_i,
    input logic [31:0] wdata_i,
    input logic        wr_i,
    input logic        rd_i,
    input logic [31:0] rdata_o,
    input logic        irq_o,
    input logic        nv_load_i,
    input logic        nv_dest_i,
    input logic        mgmt_pins_en_i,
    input logic        ext_mdc_o,
    input logic        ext_mdio_o,
    input logic        ext_mdio_oe_o,
    input logic        int_mdio_oe_o
);
    logic       dest;
    logic       bext;
    logic [1:0] ien;
    int         busy;
    int         hi;
    wire  [1:0] op = wdata_i[27:26];
    wire        start = wr_i && addr_i == `CMD_OFFSET && (op == `OP_WRITE || op == `OP_READ)
                        && !wdata_i[`CMD_READY_BIT] && mgmt_pins_en_i && busy == 0;
    wire        known = addr_i == `CMD_OFFSET || addr_i == `CFG_OFFSET
                        || addr_i == `IRQ_STATUS_OFFSET || addr_i == `IRQ_ENABLE_OFFSET;

    // ----------------------------------------
    // shadow state; busy ends just before the frame, so a poll never overlaps it
    // ----------------------------------------
    always @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            dest <= 1'b0;
            bext <= 1'b0;
            ien <= 2'b00;
            busy <= 0;
            hi <= 0;
        end
        else
        begin
            if (nv_load_i)
                dest <= nv_dest_i;
            else if (wr_i && addr_i == `CFG_OFFSET)
                dest <= wdata_i[`CFG_DEST_BIT];
            if (wr_i && addr_i == `IRQ_ENABLE_OFFSET)
                ien <= wdata_i[1:0];
            if (start)
                bext <= dest;
            busy <= start ? 128 * MDC_HALF : (busy != 0 ? busy - 1 : 0);
            hi <= ext_mdc_o ? hi + 1 : 0;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    property p_rd_idle;
        !rd_i |=> rdata_o == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_unmapped;
        rd_i && !known |=> rdata_o == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_pins_off;
        !mgmt_pins_en_i [*2] |-> !ext_mdc_o && !ext_mdio_oe_o && !ext_mdio_o;
    endproperty
    a_pins_off: assert property (p_pins_off) else $error("pads active while disabled");
    property p_start_ext;
        start && dest |-> ##[1:2] ext_mdio_oe_o && ext_mdio_o;
    endproperty
    a_start_ext: assert property (p_start_ext) else $error("external frame not started");
    property p_start_int;
        start && !dest |-> ##[1:2] int_mdio_oe_o;
    endproperty
    a_start_int: assert property (p_start_int) else $error("internal frame not started");
    property p_int_quiet;
        busy != 0 && !bext |-> !ext_mdc_o && !ext_mdio_oe_o;
    endproperty
    a_int_quiet: assert property (p_int_quiet) else $error("external pads move for internal");
    property p_mdc_high;
        $fell(ext_mdc_o) |-> hi == MDC_HALF;
    endproperty
    a_mdc_high: assert property (p_mdc_high) else $error("clock high time wrong");
    property p_mdio_steady;
        ext_mdc_o && $past(ext_mdc_o) |-> $stable(ext_mdio_o);
    endproperty
    a_mdio_steady: assert property (p_mdio_steady) else $error("data moved while clock high");
    property p_irq_masked;
        ien == 2'b00 |-> !irq_o;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("interrupt while masked");

    c_ext: cover property (start && dest);
    c_int: cover property (start && !dest);
    c_irq: cover property ($rose(irq_o));
    c_pins: cover property (!mgmt_pins_en_i && wr_i);
endmodule // phy_mgmt_checker

bind phy_management_access phy_mgmt_checker #(.MDC_HALF(MDC_HALF)) i_phy_mgmt_checker (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .nv_load_i(nv_load_i),
    .nv_dest_i(nv_dest_i), .mgmt_pins_en_i(mgmt_pins_en_i), .ext_mdc_o(ext_mdc_o),
    .ext_mdio_o(ext_mdio_o), .ext_mdio_oe_o(ext_mdio_oe_o), .int_mdio_oe_o(int_mdio_oe_o)
);

//--- testbench/phy_management_access_test.sv
// self-checking bench for the phy management access block
`timescale 1ns/1ps
`include "phy_mgmt_consts.vh"
module phy_management_access_test;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        nv_load = 1'b0;
    logic        nv_dest = 1'b0;
    logic        pins_en = 1'b1;
    logic        e_fail = 1'b0;
    logic [31:0] rdata;
    logic [31:0] v;
    logic        irq, e_mdc, e_out, e_oe, i_mdc, i_out, i_oe, e_drv, e_val, i_drv, i_val;
    // both lines carry a pull-up, so a released line reads high
    wire         e_in = e_oe ? e_out : (e_drv ? e_val : 1'b1);
    wire         i_in = i_oe ? i_out : (i_drv ? i_val : 1'b1);
    int          mismatches = 0;
    int          n_checks = 0;

    always #4 clk = ~clk;

    phy_management_access #(.MDC_HALF(8)) i_phy_management_access (
        .ref_clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .nv_load_i(nv_load),
        .nv_phy_port_i(5'h13), .nv_dest_i(nv_dest), .mgmt_pins_en_i(pins_en),
        .ext_mdc_o(e_mdc), .ext_mdio_i(e_in), .ext_mdio_o(e_out), .ext_mdio_oe_o(e_oe),
        .int_mdc_o(i_mdc), .int_mdio_i(i_in), .int_mdio_o(i_out), .int_mdio_oe_o(i_oe));
    phy_model #(.PORT(5'h13)) i_phy_model_ext (
        .mdc_i(e_mdc), .mdio_i(e_in), .fail_i(e_fail), .drv_o(e_drv), .val_o(e_val));
    phy_model #(.PORT(5'h00)) i_phy_model_int (
        .mdc_i(i_mdc), .mdio_i(i_in), .fail_i(1'b0), .drv_o(i_drv), .val_o(i_val));

    // ----------------------------------------
    // bus and compare helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [11:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    function automatic logic [31:0] cmd(input logic [1:0] op, input logic [4:0] r,
                                        input logic [15:0] d, input logic ie);
        return {2'b00, ie, 1'b0, op, 5'h00, r, d};
    endfunction
    task automatic wait_ready();
        for (int k = 0; k < 1000; k++)
        begin
            rd_reg(`CMD_OFFSET);
            if (v[`CMD_READY_BIT] === 1'b1)
                return;
        end
        chk("ready_wait", 32'h1, v[`CMD_READY_BIT]);
    endtask
    task automatic run(input logic [1:0] op, input logic [4:0] r, input logic [15:0] d);
        wr_reg(`CMD_OFFSET, cmd(op, r, d, 1'b0));
        wait_ready();
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd_reg(`CMD_OFFSET);
        chk("cmd_flags", 32'h1, v[30:28]);
        rd_reg(`CFG_OFFSET);
        chk("cfg_reset", 32'h0, v);
        rd_reg(12'h100);
        chk("unmapped", 32'h0, v);
        rd_reg(`IRQ_CLEAR_OFFSET);
        chk("clear_read", 32'h0, v);
    endtask
    task automatic t_nv();
        @(posedge clk);
        nv_load <= 1'b1;
        nv_dest <= 1'b1;
        @(posedge clk);
        nv_load <= 1'b0;
        rd_reg(`CFG_OFFSET);
        chk("nv_port", 32'h13, v[25:21]);
        chk("nv_dest", 32'h1, v[31]);
    endtask
    task automatic t_ext_write();
        wr_reg(`IRQ_ENABLE_OFFSET, 32'h0000_0003);
        wr_reg(`CMD_OFFSET, cmd(`OP_WRITE, 5'h1f, 16'ha5c3, 1'b1));
        rd_reg(`CMD_OFFSET);
        chk("ready_busy", 32'h0, v[28]);
        wait_ready();
        chk("phy_mem", 32'ha5c3, i_phy_model_ext.mem[31]);
        chk("phy_port", 32'h13, i_phy_model_ext.port);
        chk("preamble", 32'h20, i_phy_model_ext.npre);
        chk("irq_done", 32'h1, irq);
        rd_reg(`IRQ_STATUS_OFFSET);
        chk("status", 32'h1, v[1:0]);
        wr_reg(`IRQ_CLEAR_OFFSET, 32'h0000_0003);
        chk("irq_clear", 32'h0, irq);
    endtask
    task automatic t_ext_read();
        run(`OP_READ, 5'h1f, 16'h0000);
        chk("rd_data", 32'ha5c3, v[15:0]);
        chk("rd_reg", 32'h1f, v[20:16]);
        chk("rd_err", 32'h0, v[30]);
    endtask
    task automatic t_int();
        wr_reg(`CFG_OFFSET, 32'h00e0_0000);
        run(`OP_WRITE, 5'h03, 16'h1234);
        chk("int_mem", 32'h1234, i_phy_model_int.mem[3]);
        chk("int_port", 32'h0, i_phy_model_int.port);
        run(`OP_READ, 5'h03, 16'h0000);
        chk("int_data", 32'h1234, v[15:0]);
    endtask
    task automatic t_fail();
        wr_reg(`CFG_OFFSET, 32'h8260_0000);
        e_fail <= 1'b1;
        run(`OP_READ, 5'h1f, 16'h0000);
        chk("fail_err", 32'h1, v[30]);
        chk("fail_data", 32'hffff, v[15:0]);
        chk("irq_fail", 32'h1, irq);
        e_fail <= 1'b0;
        wr_reg(`IRQ_CLEAR_OFFSET, 32'h0000_0003);
        run(`OP_READ, 5'h1f, 16'h0000);
        chk("err_again", 32'h0, v[30]);
    endtask
    task automatic t_idle_cmd(input logic [1:0] op, input logic en);
        pins_en <= en;
        wr_reg(`CMD_OFFSET, cmd(op, 5'h02, 16'h0000, 1'b0));
        repeat (20) @(posedge clk);
        rd_reg(`CMD_OFFSET);
        chk("idle_ready", 32'h1, v[28]);
        chk("idle_pads", 32'h0, {e_mdc, e_oe, i_mdc, i_oe});
        pins_en <= 1'b1;
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        #240000;
        mismatches++;
        give_verdict();
    end

    initial
    begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_nv();
        t_ext_write();
        t_ext_read();
        t_int();
        t_fail();
        t_idle_cmd(2'b00, 1'b1);
        t_idle_cmd(2'b11, 1'b1);
        t_idle_cmd(`OP_READ, 1'b0);
        give_verdict();
    end
endmodule // phy_management_access_test
